// ---- rtl/icg_pkg.sv ----
// Package: register map, field layout, reset values and timing of the commutation generator
package icg_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ICG_REG_RES_SPACING = 8'h06;
  localparam logic [7:0] ICG_REG_INDEX_OFF = 8'h07;
  localparam logic [7:0] ICG_REG_OUT_BEHAV = 8'h08;
  localparam logic [7:0] ICG_REG_COM_OFF = 8'h09;
  localparam logic [7:0] ICG_REG_STATUS = 8'h0A;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int ICG_RES_LSB = 0;
  localparam int ICG_SPACING_LSB = 4;
  localparam int ICG_INV_LSB = 0;
  localparam int ICG_POLE_LSB = 2;
  localparam int ICG_SU_BIT = 4;
  localparam int ICG_DIR_BIT = 5;
  localparam int ICG_HYS_LSB = 6;
  localparam int ICG_STAT_KNOWN_BIT = 0;
  localparam int ICG_STAT_CATCHUP_BIT = 1;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] ICG_RES_RST = 4'h0;
  localparam logic [2:0] ICG_SPACING_RST = 3'h2;
  localparam logic [7:0] ICG_INDEX_OFF_RST = 8'h00;
  localparam logic [1:0] ICG_INV_RST = 2'h0;
  localparam logic [1:0] ICG_POLE_RST = 2'h0;
  localparam logic ICG_SU_RST = 1'b0;
  localparam logic ICG_DIR_RST = 1'b0;
  localparam logic [1:0] ICG_HYS_RST = 2'h0;
  localparam logic [7:0] ICG_COM_OFF_RST = 8'h00;

  // ----------------------------------------------------------------
  // Encodings and limits
  // ----------------------------------------------------------------
  localparam logic [3:0] ICG_RES_CODE_MAX = 4'hA;
  localparam logic [1:0] ICG_INV_B = 2'h1;
  localparam logic [1:0] ICG_INV_A = 2'h2;
  localparam logic [1:0] ICG_POLE_2 = 2'h0;
  localparam logic [1:0] ICG_POLE_4 = 2'h1;
  localparam logic [4:0] ICG_HYS_BASE_CNT = 5'h02;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int ICG_CLK_PERIOD_NS = 8;
  localparam int ICG_EDGE_SPACING_BASE_NS = 125;

  typedef enum logic [1:0] {
    ST_RESET,
    ST_ACQUIRE,
    ST_CATCHUP,
    ST_RUN
  } icg_state_e;

endpackage

// ---- rtl/icg_pos_if.sv ----
// Interface: position and commutation settings from the core to the commutation stage
interface icg_pos_if;
  logic [11:0] pos;
  logic known;
  logic [1:0] pole_sel;
  logic [7:0] com_off;
  logic u;
  logic v;
  logic w;

  modport core (output pos, output known, output pole_sel, output com_off, input u, input v, input w);
  modport gen (input pos, input known, input pole_sel, input com_off, output u, output v, output w);
endinterface

// ---- rtl/icg_comm.sv ----
// Commutation stage: three 120 degree shifted U/V/W tracks from the tracked position
module icg_comm
  import icg_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // Position from core
  icg_pos_if.gen pos_if
);

  logic [11:0] cpos;
  logic [11:0] elec;
  logic [14:0] prod;
  logic [2:0] sector;

  // ----------------------------------------------------------------
  // Sector decode
  // ----------------------------------------------------------------
  always_comb begin
    cpos = pos_if.pos + {pos_if.com_off, 4'h0};
    case (pos_if.pole_sel)
      ICG_POLE_2: elec = cpos;
      ICG_POLE_4: elec = {cpos[10:0], 1'b0};
      default: elec = {cpos[9:0], 2'b00};
    endcase
    // Six equal sectors of one electrical turn
    prod = 15'({3'h0, elec} * 15'h0006);
    sector = prod[14:12];
  end

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i || !pos_if.known) begin
      pos_if.u <= 1'b0;
      pos_if.v <= 1'b0;
      pos_if.w <= 1'b0;
    end else begin
      pos_if.u <= (sector < 3'h3);
      pos_if.v <= (sector >= 3'h2) && (sector <= 3'h4);
      pos_if.w <= (sector >= 3'h4) || (sector == 3'h0);
    end
  end

  comm_low_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    !pos_if.known |=> ({pos_if.u, pos_if.v, pos_if.w} == 3'b000))
    else $error("Commutation outputs not low while position unknown");

  comm_phase_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    pos_if.known |=> ({pos_if.u, pos_if.v, pos_if.w} != 3'b000) && ({pos_if.u, pos_if.v, pos_if.w} != 3'b111))
    else $error("Commutation tracks not 120 degrees apart");

endmodule

// ---- rtl/icg_top.sv ----
// Top: register set, direction, hysteresis, edge spacing, quadrature and index generation
// Overview of operation
// - Full resolution gives 4096 edges and 4096 steps per turn, tracked live.
// - Resolution code 0x0 is factor 1024, halving per step down to 1 at 0xA.
// - Changing resolution triggers an internal module reset and position reacquisition.
// - Position is available full 12-bit and reduced to the programmed resolution.
// - Quadrature and commutation derive from one position, each with its own zero.
// - Invert field: 0 none, 1 B only, 2 A only, 3 both.
// - Without inversion A and B are high at the zero point with Z high.
// - At 10-bit resolution edges sit within 40 to 60 percent of the period.
// - Hysteresis codes 0 to 3 give 0.17, 0.35, 0.7, 1.4 degrees.
// - Return edge after reversal only beyond hysteresis; same-direction edges repeat exactly.
// - Index offset places Z at value times 360/256 degrees.
// - Edge spacing code sets least time between events, 125 ns doubling to 16 us.
// - Default spacing limits A to 500 kHz.
// - Direction bit 0 counts up counterclockwise, 1 counts up clockwise.
// - Startup mode 0 holds A, B, Z at 111 until position is known.
// - Startup mode 1 counts edges out until the absolute position is reached.
// - Commutation produces U, V, W rectangles 120 degrees apart.
// - Pole field repeats commutation once, twice, or four times per turn.
// - Commutation offset moves the U rising edge by minus 360/256 per count.
// - Commutation outputs stay low while position is unknown.
module icg_top
  import icg_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // Converter angle
  input wire logic [11:0] angle_i,
  input wire logic angle_valid_i,
  // Incremental outputs
  output logic a_o,
  output logic b_o,
  output logic z_o,
  // Commutation outputs
  output logic u_o,
  output logic v_o,
  output logic w_o,
  // Position readout
  output logic [11:0] pos_full_o,
  output logic [11:0] pos_reduced_o,
  output logic pos_known_o
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Bits dropped from the 12-bit position; codes above 0xA clamp to one period per turn
  function automatic logic [3:0] res_shift(input logic [3:0] code);
    res_shift = (code > ICG_RES_CODE_MAX) ? ICG_RES_CODE_MAX : code;
  endfunction

  // Least cycles between position events, rounded up to whole clocks
  function automatic logic [10:0] spacing_cycles(input logic [2:0] code);
    spacing_cycles = 11'((ICG_EDGE_SPACING_BASE_NS * (1 << code) + ICG_CLK_PERIOD_NS - 1) / ICG_CLK_PERIOD_NS);
  endfunction

  // Hysteresis in 12-bit counts: 2, 4, 8, 16 (about 0.18 to 1.41 degrees)
  function automatic logic [4:0] hys_counts(input logic [1:0] code);
    hys_counts = 5'(ICG_HYS_BASE_CNT << code);
  endfunction

  // Backlash filter: the tracked point follows only once the angle leaves the band
  function automatic logic [11:0] hyst_next(input logic [11:0] filt, input logic [11:0] ang, input logic [4:0] h);
    logic [11:0] d;
    logic [11:0] hw;
    d = ang - filt;
    hw = {7'h00, h};
    if (!d[11] && (d > hw)) begin
      hyst_next = ang - hw;
    end else if (d[11] && ((12'h000 - d) > hw)) begin
      hyst_next = ang + hw;
    end else begin
      hyst_next = filt;
    end
  endfunction

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic [3:0] res_sel_ff;
  logic [2:0] spacing_sel_ff;
  logic [7:0] index_off_ff;
  logic [1:0] inv_sel_ff;
  logic [1:0] pole_sel_ff;
  logic su_mode_ff;
  logic dir_sel_ff;
  logic [1:0] hys_sel_ff;
  logic [7:0] com_off_ff;
  logic res_change;

  assign res_change = reg_wr_i && (reg_addr_i == ICG_REG_RES_SPACING) &&
                      (reg_wdata_i[ICG_RES_LSB +: 4] != res_sel_ff);

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      res_sel_ff <= ICG_RES_RST;
      spacing_sel_ff <= ICG_SPACING_RST;
      index_off_ff <= ICG_INDEX_OFF_RST;
      inv_sel_ff <= ICG_INV_RST;
      pole_sel_ff <= ICG_POLE_RST;
      su_mode_ff <= ICG_SU_RST;
      dir_sel_ff <= ICG_DIR_RST;
      hys_sel_ff <= ICG_HYS_RST;
      com_off_ff <= ICG_COM_OFF_RST;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        ICG_REG_RES_SPACING: begin
          res_sel_ff <= reg_wdata_i[ICG_RES_LSB +: 4];
          spacing_sel_ff <= reg_wdata_i[ICG_SPACING_LSB +: 3];
        end
        ICG_REG_INDEX_OFF: index_off_ff <= reg_wdata_i;
        ICG_REG_OUT_BEHAV: begin
          inv_sel_ff <= reg_wdata_i[ICG_INV_LSB +: 2];
          pole_sel_ff <= reg_wdata_i[ICG_POLE_LSB +: 2];
          su_mode_ff <= reg_wdata_i[ICG_SU_BIT];
          dir_sel_ff <= reg_wdata_i[ICG_DIR_BIT];
          hys_sel_ff <= reg_wdata_i[ICG_HYS_LSB +: 2];
        end
        ICG_REG_COM_OFF: com_off_ff <= reg_wdata_i;
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  icg_state_e state_ff;
  logic [11:0] pos_ff;
  logic [11:0] filt_ff;
  logic [10:0] timer_ff;
  logic [11:0] eff_angle;
  logic [11:0] step_dist;

  // Mirror the angle so that positive counting follows the chosen rotation sense
  assign eff_angle = dir_sel_ff ? (12'h000 - angle_i) : angle_i;
  assign step_dist = filt_ff - pos_ff;

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i || res_change) begin
      state_ff <= ST_RESET;
    end else begin
      case (state_ff)
        ST_RESET: state_ff <= ST_ACQUIRE;
        ST_ACQUIRE: begin
          if (angle_valid_i) begin
            state_ff <= su_mode_ff ? ST_CATCHUP : ST_RUN;
          end
        end
        ST_CATCHUP: begin
          if (pos_ff == filt_ff) begin
            state_ff <= ST_RUN;
          end
        end
        ST_RUN: state_ff <= ST_RUN;
        default: state_ff <= ST_RESET;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Position tracking with edge spacing
  // ----------------------------------------------------------------
  // One step per event keeps every 12-bit count visible as an edge at full resolution;
  // a slow spacing setting therefore caps the trackable speed.
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i || state_ff == ST_RESET) begin
      pos_ff <= 12'h000;
      filt_ff <= 12'h000;
      timer_ff <= 11'h000;
    end else begin
      case (state_ff)
        ST_ACQUIRE: begin
          if (angle_valid_i) begin
            filt_ff <= eff_angle;
            pos_ff <= su_mode_ff ? 12'h000 : eff_angle;
          end
          timer_ff <= 11'h000;
        end
        ST_CATCHUP, ST_RUN: begin
          if (angle_valid_i) begin
            filt_ff <= hyst_next(filt_ff, eff_angle, hys_counts(hys_sel_ff));
          end
          if (timer_ff != 11'h000) begin
            timer_ff <= timer_ff - 11'h001;
          end else if (pos_ff != filt_ff) begin
            pos_ff <= step_dist[11] ? (pos_ff - 12'h001) : (pos_ff + 12'h001);
            timer_ff <= spacing_cycles(spacing_sel_ff) - 11'h001;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Quadrature and index
  // ----------------------------------------------------------------
  logic [11:0] rel_pos;
  logic [11:0] quad_pos;
  logic hold_abz;

  assign rel_pos = pos_ff - {index_off_ff, 4'h0};
  assign quad_pos = rel_pos >> res_shift(res_sel_ff);
  assign hold_abz = (state_ff == ST_RESET) || (state_ff == ST_ACQUIRE);

  // Exact integer decode keeps every edge on its nominal count
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i || hold_abz) begin
      a_o <= 1'b1;
      b_o <= 1'b1;
      z_o <= 1'b1;
    end else begin
      a_o <= ((quad_pos[1:0] == 2'b00) || (quad_pos[1:0] == 2'b11)) ^ inv_sel_ff[1];
      b_o <= ((quad_pos[1:0] == 2'b00) || (quad_pos[1:0] == 2'b01)) ^ inv_sel_ff[0];
      z_o <= (quad_pos == 12'h000);
    end
  end

  // ----------------------------------------------------------------
  // Position readout
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      pos_full_o <= 12'h000;
      pos_reduced_o <= 12'h000;
      pos_known_o <= 1'b0;
    end else begin
      pos_full_o <= eff_angle;
      pos_reduced_o <= eff_angle >> res_shift(res_sel_ff);
      pos_known_o <= (state_ff == ST_RUN);
    end
  end

  // ----------------------------------------------------------------
  // Commutation
  // ----------------------------------------------------------------
  icg_pos_if pos_bus ();

  assign pos_bus.pos = pos_ff;
  assign pos_bus.known = (state_ff == ST_RUN);
  assign pos_bus.pole_sel = pole_sel_ff;
  assign pos_bus.com_off = com_off_ff;
  assign u_o = pos_bus.u;
  assign v_o = pos_bus.v;
  assign w_o = pos_bus.w;

  icg_comm u_comm (
    .core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i),
    .pos_if(pos_bus.gen)
  );

  // ----------------------------------------------------------------
  // Register read
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i || !reg_rd_i) begin
      reg_rdata_o <= 8'h00;
    end else begin
      case (reg_addr_i)
        ICG_REG_RES_SPACING: reg_rdata_o <= {1'b0, spacing_sel_ff, res_sel_ff};
        ICG_REG_INDEX_OFF: reg_rdata_o <= index_off_ff;
        ICG_REG_OUT_BEHAV: reg_rdata_o <= {hys_sel_ff, dir_sel_ff, su_mode_ff, pole_sel_ff, inv_sel_ff};
        ICG_REG_COM_OFF: reg_rdata_o <= com_off_ff;
        ICG_REG_STATUS: reg_rdata_o <= {6'h00, state_ff == ST_CATCHUP, state_ff == ST_RUN};
        default: reg_rdata_o <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  startup_hold_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (state_ff == ST_ACQUIRE) |=> ({a_o, b_o, z_o} == 3'b111))
    else $error("ABZ not held at 111 while acquiring");

  res_reset_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    res_change |=> (state_ff == ST_RESET) ##1 (state_ff == ST_ACQUIRE))
    else $error("Resolution change did not restart acquisition");

  spacing_gap_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (state_ff == ST_RUN && $past(state_ff) == ST_RUN && pos_ff != $past(pos_ff)) |-> ($past(timer_ff) == 11'h000))
    else $error("Position event before edge spacing elapsed");

  pos_step_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (state_ff == ST_RUN && $past(state_ff) == ST_RUN && pos_ff != $past(pos_ff))
      |-> ((12'(pos_ff - $past(pos_ff)) == 12'h001) || (12'(pos_ff - $past(pos_ff)) == 12'hFFF)))
    else $error("Position moved more than one count");

  zero_point_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (state_ff == ST_RUN && inv_sel_ff == 2'h0 && rel_pos == 12'h000 && !res_change) |=> (a_o && b_o && z_o))
    else $error("A and B not high at the zero point");

  invert_both_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (state_ff == ST_RUN && inv_sel_ff == 2'h3 && rel_pos == 12'h000 && !res_change) |=> (!a_o && !b_o && z_o))
    else $error("Inversion of A and B not applied");

  catchup_end_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (state_ff == ST_CATCHUP && pos_ff == filt_ff && !res_change) |=> (state_ff == ST_RUN))
    else $error("Catch-up did not end at the absolute position");

  read_index_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (reg_rd_i && reg_addr_i == ICG_REG_INDEX_OFF) |=> (reg_rdata_o == $past(index_off_ff)))
    else $error("Index offset read back wrong");

endmodule

// ---- dv/icg_counter_model.sv ----
// Partner model: downstream quadrature counter that takes every edge and logs edge spacing
module icg_counter_model (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // Quadrature lines and control
  input wire logic a_i,
  input wire logic b_i,
  input wire logic clear_i,
  // Observations
  output logic [15:0] edges_o,
  output logic [15:0] min_gap_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] prev_ff;
  logic [15:0] edge_cnt_ff;
  logic [15:0] gap_ff;
  logic [15:0] min_gap_ff;
  logic first_ff;
  assign edges_o = edge_cnt_ff;
  assign min_gap_o = min_gap_ff;
  // A double transition is counted once, as a real counter would lose it
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i || clear_i) begin
      prev_ff <= {a_i, b_i};
      edge_cnt_ff <= 16'h0000;
      gap_ff <= 16'h0000;
      min_gap_ff <= 16'hFFFF;
      first_ff <= 1'b1;
    end else begin
      prev_ff <= {a_i, b_i};
      if ({a_i, b_i} != prev_ff) begin
        edge_cnt_ff <= edge_cnt_ff + 16'h0001;
        gap_ff <= 16'h0001;
        first_ff <= 1'b0;
        if (!first_ff && gap_ff < min_gap_ff) begin
          min_gap_ff <= gap_ff;
        end
      end else if (gap_ff != 16'hFFFF) begin
        gap_ff <= gap_ff + 16'h0001;
      end
    end
  end
endmodule

// ---- dv/incremental_commutation_generator_test.sv ----
// Testbench: register port, quadrature, index and commutation outputs of the generator
module incremental_commutation_generator_test import icg_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [3:0] res;
    logic [2:0] sp;
    logic [1:0] inv;
    logic [7:0] ioff;
    logic dir;
    logic su;
    logic [1:0] pole;
    logic [1:0] hys;
    logic [7:0] com;
    logic [11:0] ang;
    logic [5:0] want;
  } icg_row_s;
  logic core_clk_i, reset_n_i, reg_wr_i, reg_rd_i, angle_valid_i, clr, seen;
  logic a_o, b_o, z_o, u_o, v_o, w_o, pos_known_o;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, d;
  logic [11:0] angle_i, pos_full_o, pos_reduced_o;
  logic [15:0] edges, min_gap;
  logic [5:0] outs;
  int failures = 0;
  int n_tests = 0;
  int nt [8] = '{16, 32, 63, 125, 250, 500, 1000, 2000};
  icg_row_s r;
  icg_row_s b = '0;
  icg_row_s rows [8] = '{
    '{4'h0, 3'h2, 2'h0, 8'h00, 1'b0, 1'b0, 2'h0, 2'h0, 8'h00, 12'h000, 6'h3D},
    '{4'h0, 3'h2, 2'h1, 8'h00, 1'b0, 1'b0, 2'h1, 2'h0, 8'h01, 12'h001, 6'h05},
    '{4'h0, 3'h2, 2'h2, 8'h10, 1'b1, 1'b0, 2'h2, 2'h1, 8'h20, 12'h105, 6'h04},
    '{4'h0, 3'h2, 2'h3, 8'hFF, 1'b0, 1'b0, 2'h3, 2'h2, 8'h80, 12'hFF0, 6'h09},
    '{4'hC, 3'h2, 2'h0, 8'h40, 1'b1, 1'b0, 2'h0, 2'h3, 8'hFF, 12'h7A3, 6'h12},
    '{4'hA, 3'h2, 2'h1, 8'h00, 1'b0, 1'b0, 2'h1, 2'h0, 8'h55, 12'h800, 6'h12},
    '{4'h5, 3'h1, 2'h0, 8'h03, 1'b1, 1'b0, 2'h2, 2'h0, 8'h10, 12'h2C0, 6'h32},
    '{4'h1, 3'h0, 2'h2, 8'h80, 1'b0, 1'b0, 2'h3, 2'h1, 8'h01, 12'h804, 6'h25}};
  assign outs = {a_o, b_o, z_o, u_o, v_o, w_o};

  icg_top icg_top_i (.core_clk_i, .reset_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .angle_i, .angle_valid_i, .a_o, .b_o, .z_o, .u_o, .v_o, .w_o, .pos_full_o, .pos_reduced_o, .pos_known_o);
  icg_counter_model icg_counter_model_i (.core_clk_i, .reset_n_i, .a_i(a_o), .b_i(b_o), .clear_i(clr),
    .edges_o(edges), .min_gap_o(min_gap));

  initial begin
    core_clk_i = 1'b0;
    forever #4 core_clk_i = ~core_clk_i;
  end

  // ----------------------------------------------------------------
  // Expected values
  // ----------------------------------------------------------------
  function automatic logic [11:0] eff(icg_row_s x);
    return x.dir ? 12'h000 - x.ang : x.ang;
  endfunction
  function automatic logic [3:0] rcl(icg_row_s x);
    return (x.res > 4'hA) ? 4'hA : x.res;
  endfunction
  function automatic logic [15:0] exp_out(icg_row_s x);
    logic [11:0] q, c;
    logic [14:0] m;
    logic [2:0] s;
    q = (eff(x) - {x.ioff, 4'h0}) >> rcl(x);
    c = eff(x) + {x.com, 4'h0};
    c = x.pole[1] ? c << 2 : (x.pole[0] ? c << 1 : c);
    m = c * 15'h0006;
    s = m[14:12];
    return 16'({~(q[1] ^ q[0]) ^ x.inv[1], ~q[1] ^ x.inv[0], q == 12'h000,
      s <= 3'h2, s >= 3'h2 && s <= 3'h4, s >= 3'h4 || s == 3'h0});
  endfunction

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic conclude;
    if (failures == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] seen_v, input logic [15:0] exp_v);
    n_tests++;
    if (seen_v !== exp_v) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp_v, seen_v);
    end
  endtask
  task automatic bail(input logic bad);
    if (bad) begin
      failures++;
      conclude();
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask
  // Strobe released one edge later, so back-to-back calls never assign twice in a step
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    reg_addr_i <= a;
    reg_wdata_i <= v;
    reg_wr_i <= 1'b1;
    cyc(1);
    reg_wr_i <= 1'b0;
    cyc(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    cyc(1);
    reg_rd_i <= 1'b0;
    #1;
    check("reg_rdata_o", 16'(reg_rdata_o), 16'(e));
    cyc(1);
  endtask
  task automatic wait_known;
    for (int i = 0; i < 20000 && pos_known_o !== 1'b1; i++) cyc(1);
    bail(pos_known_o !== 1'b1);
    cyc(3);
  endtask
  task automatic wait_edges(input int n);
    for (int i = 0; i < 20000 && edges < n; i++) cyc(1);
    bail(edges < n);
  endtask
  task automatic start(input icg_row_s x);
    reset_n_i <= 1'b0;
    angle_valid_i <= 1'b0;
    cyc(4);
    reset_n_i <= 1'b1;
    cyc(1);
    wr(ICG_REG_RES_SPACING, {1'b0, x.sp, x.res});
    wr(ICG_REG_INDEX_OFF, x.ioff);
    wr(ICG_REG_OUT_BEHAV, {x.hys, x.dir, x.su, x.pole, x.inv});
    wr(ICG_REG_COM_OFF, x.com);
    angle_i <= x.ang;
    angle_valid_i <= 1'b1;
    cyc(1);
  endtask
  task automatic clear_cnt;
    clr <= 1'b1;
    cyc(1);
    clr <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    reset_n_i = 1'b0;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    reg_addr_i = 8'h00;
    reg_wdata_i = 8'h00;
    angle_i = 12'h000;
    angle_valid_i = 1'b0;
    clr = 1'b0;
    cyc(4);
    reset_n_i <= 1'b1;
    cyc(20);
    check("outs", 16'(outs), 16'h0038);
    check("known", 16'(pos_known_o), 16'h0000);
    rd(ICG_REG_RES_SPACING, 8'h20);
    rd(ICG_REG_INDEX_OFF, 8'h00);
    rd(ICG_REG_OUT_BEHAV, 8'h00);
    rd(ICG_REG_COM_OFF, 8'h00);
    wr(8'h0B, 8'hFF);
    rd(8'h0B, 8'h00);
    wr(ICG_REG_STATUS, 8'hFF);
    rd(ICG_REG_STATUS, 8'h00);
    wr(ICG_REG_RES_SPACING, 8'hA0);
    rd(ICG_REG_RES_SPACING, 8'h20);
    foreach (rows[k]) begin
      r = rows[k];
      start(r);
      wait_known();
      check("outs", 16'(outs), exp_out(r));
      check("outs row", 16'(outs), 16'(r.want));
      check("pos_full_o", 16'(pos_full_o), 16'(eff(r)));
      check("pos_reduced_o", 16'(pos_reduced_o), 16'(eff(r) >> rcl(r)));
      rd(ICG_REG_RES_SPACING, {1'b0, r.sp, r.res});
      rd(ICG_REG_INDEX_OFF, r.ioff);
      rd(ICG_REG_OUT_BEHAV, {r.hys, r.dir, r.su, r.pole, r.inv});
      rd(ICG_REG_COM_OFF, r.com);
      rd(ICG_REG_STATUS, 8'h01);
    end
    // Every spacing code, three steps each
    for (int s = 0; s < 8; s++) begin
      r = b;
      r.sp = 3'(s);
      start(r);
      wait_known();
      clear_cnt();
      angle_i <= 12'h005;
      wait_edges(3);
      cyc(2 * nt[s]);
      r.ang = 12'h003;
      check("edges", edges, 16'h0003);
      check("min_gap", 16'(min_gap >= nt[s]), 16'h0001);
      check("outs", 16'(outs), exp_out(r));
    end
    // Reversal inside and beyond the widest hysteresis band
    r = b;
    r.hys = 2'h3;
    r.ang = 12'h064;
    start(r);
    wait_known();
    clear_cnt();
    angle_i <= 12'h06E;
    cyc(100);
    check("edges", edges, 16'h0000);
    angle_i <= 12'h078;
    wait_edges(4);
    cyc(40);
    r.ang = 12'h068;
    check("edges", edges, 16'h0004);
    check("outs", 16'(outs), exp_out(r));
    angle_i <= 12'h064;
    cyc(100);
    check("edges", edges, 16'h0004);
    angle_i <= 12'h050;
    wait_edges(12);
    cyc(40);
    r.ang = 12'h060;
    check("edges", edges, 16'h000C);
    check("outs", 16'(outs), exp_out(r));
    // Resolution change restarts the position
    reg_addr_i <= ICG_REG_RES_SPACING;
    reg_wdata_i <= 8'h02;
    reg_wr_i <= 1'b1;
    seen = 1'b0;
    for (int i = 0; i < 6; i++) begin
      cyc(1);
      reg_wr_i <= 1'b0;
      #1;
      if (pos_known_o === 1'b0) seen = 1'b1;
    end
    check("known dropped", 16'(seen), 16'h0001);
    wait_known();
    r.res = 4'h2;
    r.ang = 12'h050;
    check("outs", 16'(outs), exp_out(r));
    check("pos_reduced_o", 16'(pos_reduced_o), 16'h0014);
    wr(ICG_REG_RES_SPACING, 8'h02);
    seen = 1'b0;
    for (int i = 0; i < 10; i++) begin
      cyc(1);
      if (pos_known_o !== 1'b1) seen = 1'b1;
    end
    check("known kept", 16'(seen), 16'h0000);
    // Start-up mode 1 counts out to the absolute position
    r = b;
    r.su = 1'b1;
    r.ang = 12'h008;
    start(r);
    wait_edges(1);
    rd(ICG_REG_STATUS, 8'h02);
    #1;
    check("known", 16'(pos_known_o), 16'h0000);
    check("uvw", 16'(outs[2:0]), 16'h0000);
    wait_edges(8);
    wait_known();
    check("edges", edges, 16'h0008);
    check("outs", 16'(outs), exp_out(r));
    conclude();
  end
endmodule
